// File: frame_access_gate.sv
// address classifier and write gate for the three frames
`timescale 1ns/1ps
`default_nettype none
`include "peripheral_frame_decoder_map.svh"
module frame_access_gate
   import peripheral_frame_decoder_pkg::*;
(
   input  wire logic [`PFD_AW-1:0] addr,
   input  wire logic               size32,
   input  wire logic               we,
   input  wire logic               unlocked,
   input  wire logic               csu_permit,
   output frame_t                  sel,
   output logic                    prot,
   output logic                    flash,
   output logic                    canctl,
   output logic                    refuse
);
   function automatic logic in_rng(input addr_t a, input addr_t lo,
                                   input addr_t hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   logic f0;
   logic f1;
   logic f2;
   always_comb begin
      flash  = in_rng(addr, `PFD_FLS_LO, `PFD_FLS_HI);
      canctl = in_rng(addr, `PFD_CCTL_LO, `PFD_CCTL_HI);
      // gaps between listed ranges fall through as reserved
      f0 = in_rng(addr, `PFD_EMU_LO, `PFD_EMU_HI) || flash ||
           in_rng(addr, `PFD_KEY_LO, `PFD_KEY_HI) ||
           in_rng(addr, `PFD_EXT_LO, `PFD_EXT_HI) ||
           in_rng(addr, `PFD_TMR_LO, `PFD_TMR_HI) ||
           in_rng(addr, `PFD_PIE_LO, `PFD_PIE_HI) ||
           in_rng(addr, `PFD_VEC_LO, `PFD_VEC_HI);
      f1 = canctl || in_rng(addr, `PFD_MBOX_LO, `PFD_MBOX_HI);
      f2 = in_rng(addr, `PFD_SYS_LO, `PFD_SYS_HI) ||
           in_rng(addr, `PFD_SER_LO, `PFD_SER_HI) ||
           in_rng(addr, `PFD_XIN_LO, `PFD_XIN_HI) ||
           in_rng(addr, `PFD_MUX_LO, `PFD_MUX_HI) ||
           in_rng(addr, `PFD_DAT_LO, `PFD_DAT_HI) ||
           in_rng(addr, `PFD_EVA_LO, `PFD_EVA_HI) ||
           in_rng(addr, `PFD_EVB_LO, `PFD_EVB_HI) ||
           in_rng(addr, `PFD_SCB_LO, `PFD_SCB_HI) ||
           in_rng(addr, `PFD_BSP_LO, `PFD_BSP_HI);
      prot = in_rng(addr, `PFD_EMU_LO, `PFD_EMU_HI) || flash ||
             in_rng(addr, `PFD_KEY_LO, `PFD_KEY_HI) ||
             in_rng(addr, `PFD_VEC_LO, `PFD_VEC_HI) ||
             in_rng(addr, `PFD_SYS_LO, `PFD_SYS_HI) ||
             in_rng(addr, `PFD_MUX_LO, `PFD_MUX_HI);
      if (f0) begin
         sel = FR_MEM;
      end else if (f1) begin
         sel = FR_WIDE;
      end else if (f2) begin
         sel = FR_NARROW;
      end else begin
         sel = FR_NONE;
      end
      refuse = (sel == FR_NONE) ||
               (we && prot && !unlocked) ||
               (we && flash && !csu_permit) ||
               (canctl && !size32) ||
               ((sel == FR_NARROW) && size32);
   end
endmodule // frame_access_gate
`default_nettype wire

// File: frame_side_model.sv
// far-side model of the memory bus frame and both peripheral buses
`timescale 1ns/1ps
`default_nettype none
module frame_side_model
   import peripheral_frame_decoder_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic [4:0]  lat,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire addr_t       mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic [31:0]      mem_rdata,
   input  wire logic        wpf_req,
   input  wire logic        wpf_we,
   input  wire addr_t       wpf_addr,
   input  wire logic [31:0] wpf_wdata,
   input  wire logic        wpf_prot_ok,
   output logic [31:0]      wpf_rdata,
   output logic             wpf_ready,
   input  wire logic        npf_req,
   input  wire logic        npf_we,
   input  wire addr_t       npf_addr,
   input  wire logic [15:0] npf_wdata,
   output logic [15:0]      npf_rdata,
   output logic             npf_ready
);
   int          mem_n = 0;
   int          wpf_n = 0;
   int          npf_n = 0;
   logic [4:0]  cnt = 5'h0;
   addr_t       last_addr;
   logic [31:0] last_data;
   logic        last_we;
   logic        last_ok;
   logic [31:0] mem_pat;
   logic [31:0] wpf_pat;
   logic [15:0] npf_pat;
   assign mem_pat = {mem_addr[15:0] ^ 16'h5A5A, mem_addr[15:0]};
   assign wpf_pat = {wpf_addr[15:0] + 16'h0001, wpf_addr[15:0]};
   assign npf_pat = npf_addr[15:0] ^ 16'hC3C3;
   // released lines show the inverse so stale data never passes by luck
   assign mem_rdata = mem_req ? mem_pat : ~mem_pat;
   assign wpf_ready = wpf_req && (cnt == lat);
   assign npf_ready = npf_req && (cnt == lat);
   assign wpf_rdata = wpf_ready ? wpf_pat : ~wpf_pat;
   assign npf_rdata = npf_ready ? npf_pat : ~npf_pat;
   always @(posedge clk_sys) begin
      if (wpf_req || npf_req) begin
         cnt <= (wpf_ready || npf_ready) ? 5'h0 : cnt + 5'h1;
      end else begin
         cnt <= 5'h0;
      end
      if (mem_req) begin
         mem_n     <= mem_n + 1;
         last_addr <= mem_addr;
         last_data <= mem_wdata;
         last_we   <= mem_we;
      end
      if (wpf_ready) begin
         wpf_n     <= wpf_n + 1;
         last_addr <= wpf_addr;
         last_data <= wpf_wdata;
         last_we   <= wpf_we;
         last_ok   <= wpf_prot_ok;
      end
      if (npf_ready) begin
         npf_n     <= npf_n + 1;
         last_addr <= npf_addr;
         last_data <= {16'h0000, npf_wdata};
         last_we   <= npf_we;
      end
   end
endmodule // frame_side_model
`default_nettype wire

// File: peripheral_frame_decoder.sv
// decoder and access gate from the processor bus to three frames
`timescale 1ns/1ps
`default_nettype none
`include "peripheral_frame_decoder_map.svh"
module peripheral_frame_decoder
   import peripheral_frame_decoder_pkg::*;
#(
   parameter logic [`PFD_CNT_W-1:0] WAIT_MAX = `PFD_WAIT_MAX
) (
   input  wire logic                    clk_sys,
   input  wire logic                    sys_rst,
   input  wire logic                    cpu_req,
   input  wire logic                    cpu_we,
   input  wire logic                    cpu_size32,
   input  wire peripheral_frame_decoder_pkg::addr_t cpu_addr,
   input  wire logic [31:0]             cpu_wdata,
   input  wire logic                    prot_unlock,
   input  wire logic                    prot_lock,
   input  wire logic                    csu_permit,
   output logic                         cpu_ack,
   output logic [31:0]                  cpu_rdata,
   output logic                         mem_req,
   output logic                         mem_we,
   output logic                         mem_size32,
   output peripheral_frame_decoder_pkg::addr_t mem_addr,
   output logic [31:0]                  mem_wdata,
   input  wire logic [31:0]             mem_rdata,
   output logic                         wpf_req,
   output logic                         wpf_we,
   output logic                         wpf_size32,
   output peripheral_frame_decoder_pkg::addr_t wpf_addr,
   output logic [31:0]                  wpf_wdata,
   output logic                         wpf_prot_ok,
   input  wire logic [31:0]             wpf_rdata,
   input  wire logic                    wpf_ready,
   output logic                         npf_req,
   output logic                         npf_we,
   output peripheral_frame_decoder_pkg::addr_t npf_addr,
   output logic [15:0]                  npf_wdata,
   input  wire logic [15:0]             npf_rdata,
   input  wire logic                    npf_ready
);
   import peripheral_frame_decoder_pkg::*;

   dec_state_t r_q;
   dec_state_t r_d;
   frame_t     g_sel;
   logic       g_prot;
   logic       g_flash;
   logic       g_canctl;
   logic       g_refuse;

   frame_access_gate u_gate (
      .addr       (cpu_addr),
      .size32     (cpu_size32),
      .we         (cpu_we),
      .unlocked   (r_q.unlocked),
      .csu_permit (csu_permit),
      .sel        (g_sel),
      .prot       (g_prot),
      .flash      (g_flash),
      .canctl     (g_canctl),
      .refuse     (g_refuse)
   );

   always_comb begin
      r_d         = r_q;
      r_d.cpu_ack = 1'b0;
      r_d.mem_req = 1'b0;
      // lock wins when both instructions land together: fail safe
      if (prot_lock) begin
         r_d.unlocked = 1'b0;
      end else if (prot_unlock) begin
         r_d.unlocked = 1'b1;
      end
      case (r_q.st)
         ST_IDLE: begin
            if (cpu_req) begin
               r_d.we     = cpu_we;
               r_d.size32 = cpu_size32;
               r_d.addr   = cpu_addr;
               r_d.wdata  = cpu_wdata;
               r_d.cnt    = '0;
               // refused access never strobes a frame, so nothing moves
               if (g_refuse) begin
                  r_d.cpu_ack   = 1'b1;
                  r_d.cpu_rdata = 32'h0000_0000;
               end else if (g_sel == FR_MEM) begin
                  r_d.mem_req = 1'b1;
                  r_d.st      = ST_MEM;
               end else if (g_sel == FR_WIDE) begin
                  if (cpu_size32) begin
                     r_d.addr = {cpu_addr[`PFD_AW-1:1], 1'b0};
                  end
                  r_d.wpf_req     = 1'b1;
                  r_d.wpf_prot_ok = r_q.unlocked || !g_canctl;
                  r_d.st          = ST_WAIT;
               end else begin
                  r_d.npf_req = 1'b1;
                  r_d.st      = ST_WAIT;
               end
            end
         end
         ST_MEM: begin
            r_d.cpu_ack = 1'b1;
            r_d.cpu_rdata = r_q.we ? 32'h0000_0000 : mem_rdata;
            r_d.st = ST_IDLE;
         end
         ST_WAIT: begin
            r_d.cnt = r_q.cnt + 1'b1;
            if (r_q.wpf_req && wpf_ready) begin
               r_d.cpu_rdata = r_q.we ? 32'h0000_0000 : wpf_rdata;
               r_d.wpf_req   = 1'b0;
               r_d.cpu_ack   = 1'b1;
               r_d.st        = ST_IDLE;
            end else if (r_q.npf_req && npf_ready) begin
               r_d.cpu_rdata = r_q.we ? 32'h0000_0000 :
                               {16'h0000, npf_rdata};
               r_d.npf_req   = 1'b0;
               r_d.cpu_ack   = 1'b1;
               r_d.st        = ST_IDLE;
            end else if (r_q.cnt >= WAIT_MAX) begin
               // a silent peripheral must not hang the processor
               r_d.cpu_rdata = 32'h0000_0000;
               r_d.wpf_req   = 1'b0;
               r_d.npf_req   = 1'b0;
               r_d.cpu_ack   = 1'b1;
               r_d.st        = ST_IDLE;
            end
         end
         default: begin
            r_d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign cpu_ack     = r_q.cpu_ack;
   assign cpu_rdata   = r_q.cpu_rdata;
   assign mem_req     = r_q.mem_req;
   assign mem_we      = r_q.we;
   assign mem_size32  = r_q.size32;
   assign mem_addr    = r_q.addr;
   assign mem_wdata   = r_q.wdata;
   assign wpf_req     = r_q.wpf_req;
   assign wpf_we      = r_q.we;
   assign wpf_size32  = r_q.size32;
   assign wpf_addr    = r_q.addr;
   assign wpf_wdata   = r_q.wdata;
   assign wpf_prot_ok = r_q.wpf_prot_ok;
   assign npf_req     = r_q.npf_req;
   assign npf_we      = r_q.we;
   assign npf_addr    = r_q.addr;
   assign npf_wdata   = r_q.wdata[15:0];

   logic idle_req;
   assign idle_req = (r_q.st == ST_IDLE) && cpu_req;

   property p_mem_direct;
      @(posedge clk_sys) disable iff (sys_rst)
      idle_req && !g_refuse && (g_sel == FR_MEM) |=>
         mem_req && !wpf_req && !npf_req ##1 cpu_ack && !mem_req;
   endproperty
   a_mem_direct: assert property (p_mem_direct)
      else $error("memory frame access not one strobe then ack");

   property p_reset_locked;
      @(posedge clk_sys) sys_rst |=> !r_q.unlocked;
   endproperty
   a_reset_locked: assert property (p_reset_locked)
      else $error("protection not locked after reset");

   property p_unlock;
      @(posedge clk_sys) disable iff (sys_rst)
      prot_unlock && !prot_lock |=> r_q.unlocked;
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("unlock instruction did not unlock");

   property p_lock;
      @(posedge clk_sys) disable iff (sys_rst)
      prot_lock ##1 (!prot_unlock)[*2] |-> !r_q.unlocked;
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock instruction did not hold lock");

   property p_locked_block;
      @(posedge clk_sys) disable iff (sys_rst)
      idle_req && cpu_we && g_prot && !r_q.unlocked |=>
         cpu_ack && !mem_req && !npf_req;
   endproperty
   a_locked_block: assert property (p_locked_block)
      else $error("protected write passed while locked");

   property p_flash_gate;
      @(posedge clk_sys) disable iff (sys_rst)
      idle_req && cpu_we && g_flash && !csu_permit |=> !mem_req;
   endproperty
   a_flash_gate: assert property (p_flash_gate)
      else $error("flash write passed without security permit");

   property p_even_pair;
      @(posedge clk_sys) disable iff (sys_rst)
      wpf_req && wpf_size32 |-> !wpf_addr[0];
   endproperty
   a_even_pair: assert property (p_even_pair)
      else $error("wide frame 32-bit access on odd word");

   property p_canctl32;
      @(posedge clk_sys) disable iff (sys_rst)
      idle_req && g_canctl && !cpu_size32 |=>
         !wpf_req && cpu_ack && (cpu_rdata == 32'h0000_0000);
   endproperty
   a_canctl32: assert property (p_canctl32)
      else $error("16-bit access reached controller control");

   property p_narrow32;
      @(posedge clk_sys) disable iff (sys_rst)
      idle_req && (g_sel == FR_NARROW) && cpu_size32 |=> !npf_req;
   endproperty
   a_narrow32: assert property (p_narrow32)
      else $error("32-bit access reached narrow frame");

   property p_reserved;
      @(posedge clk_sys) disable iff (sys_rst)
      idle_req && (g_sel == FR_NONE) |=>
         cpu_ack && (cpu_rdata == 32'h0000_0000) &&
         !mem_req && !wpf_req && !npf_req;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved access not discarded with zero");

   property p_wait_bound;
      @(posedge clk_sys) disable iff (sys_rst)
      (wpf_req || npf_req) |-> (r_q.cnt <= WAIT_MAX);
   endproperty
   a_wait_bound: assert property (p_wait_bound)
      else $error("peripheral wait exceeded its bound");
endmodule // peripheral_frame_decoder
`default_nettype wire

// File: peripheral_frame_decoder_map.svh
// address map and timing constants of the peripheral frame decoder
// Overview of operation
// - The memory bus frame is decoded straight off the processor bus with no peripheral bus stage.
// - The wide peripheral frame is reached over a 32-bit peripheral bus.
// - The narrow peripheral frame is reached over a 16-bit peripheral bus.
// - Every memory bus frame register takes both 16-bit and 32-bit reads and writes.
// - Writes to protected regions have no effect until the protect unlock instruction runs.
// - The protect lock instruction blocks protected writes again until the next unlock.
// - Flash control registers are writable only when unlocked and the code security unit permits.
// - The code security unit key words form a 16-word protected region of the memory bus frame.
// - The controller control registers accept only 32-bit reads and writes.
// - A 32-bit wide frame access falls on an even word and pairs it with the next odd word.
// - In the controller region some control bits are write protected while mailbox memory is free.
// - The narrow frame services only 16-bit accesses.
// - A 32-bit access to the narrow frame is not serviced correctly.
`ifndef PERIPHERAL_FRAME_DECODER_MAP_SVH
`define PERIPHERAL_FRAME_DECODER_MAP_SVH
`define PFD_AW        22
`define PFD_CNT_W     8
`define PFD_WAIT_MAX  8'h10
`define PFD_EMU_LO    22'h00_0880
`define PFD_EMU_HI    22'h00_09FF
`define PFD_FLS_LO    22'h00_0A80
`define PFD_FLS_HI    22'h00_0ADF
`define PFD_KEY_LO    22'h00_0AE0
`define PFD_KEY_HI    22'h00_0AEF
`define PFD_EXT_LO    22'h00_0B20
`define PFD_EXT_HI    22'h00_0B3F
`define PFD_TMR_LO    22'h00_0C00
`define PFD_TMR_HI    22'h00_0C3F
`define PFD_PIE_LO    22'h00_0CE0
`define PFD_PIE_HI    22'h00_0CFF
`define PFD_VEC_LO    22'h00_0D00
`define PFD_VEC_HI    22'h00_0DFF
`define PFD_CCTL_LO   22'h00_6000
`define PFD_CCTL_HI   22'h00_60FF
`define PFD_MBOX_LO   22'h00_6100
`define PFD_MBOX_HI   22'h00_61FF
`define PFD_SYS_LO    22'h00_7010
`define PFD_SYS_HI    22'h00_702F
`define PFD_SER_LO    22'h00_7040
`define PFD_SER_HI    22'h00_705F
`define PFD_XIN_LO    22'h00_7070
`define PFD_XIN_HI    22'h00_707F
`define PFD_MUX_LO    22'h00_70C0
`define PFD_MUX_HI    22'h00_70DF
`define PFD_DAT_LO    22'h00_70E0
`define PFD_DAT_HI    22'h00_711F
`define PFD_EVA_LO    22'h00_7400
`define PFD_EVA_HI    22'h00_743F
`define PFD_EVB_LO    22'h00_7500
`define PFD_EVB_HI    22'h00_753F
`define PFD_SCB_LO    22'h00_7750
`define PFD_SCB_HI    22'h00_775F
`define PFD_BSP_LO    22'h00_7800
`define PFD_BSP_HI    22'h00_783F
`endif

// File: peripheral_frame_decoder_pkg.sv
// types of the peripheral frame decoder
`include "peripheral_frame_decoder_map.svh"
package peripheral_frame_decoder_pkg;
   typedef enum logic [1:0] {FR_NONE, FR_MEM, FR_WIDE, FR_NARROW} frame_t;
   typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_WAIT} state_t;
   typedef logic [`PFD_AW-1:0] addr_t;
   typedef struct packed {
      state_t                st;
      logic                  unlocked;
      logic [`PFD_CNT_W-1:0] cnt;
      logic                  cpu_ack;
      logic [31:0]           cpu_rdata;
      logic                  mem_req;
      logic                  wpf_req;
      logic                  npf_req;
      logic                  we;
      logic                  size32;
      addr_t                 addr;
      logic [31:0]           wdata;
      logic                  wpf_prot_ok;
   } dec_state_t;
endpackage

// File: peripheral_frame_decoder_tb_top.sv
// self-checking bench of the peripheral frame decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
   $display("[ERR] %0t mismatch got %h exp %h", $time, a, b); end end
module peripheral_frame_decoder_tb_top;
   import peripheral_frame_decoder_pkg::*;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        cpu_req = 1'b0;
   logic        cpu_we = 1'b0;
   logic        cpu_size32 = 1'b0;
   addr_t       cpu_addr = '0;
   logic [31:0] cpu_wdata = 32'h0000_0000;
   logic        prot_unlock = 1'b0;
   logic        prot_lock = 1'b0;
   logic        csu_permit = 1'b0;
   logic [4:0]  lat = 5'h00;
   logic        cpu_ack, mem_req, mem_we, wpf_req, wpf_we, wpf_prot_ok;
   logic        mem_size32, wpf_size32;
   logic        wpf_ready, npf_req, npf_we, npf_ready;
   logic [31:0] cpu_rdata, mem_wdata, mem_rdata, wpf_wdata, wpf_rdata;
   logic [15:0] npf_wdata, npf_rdata;
   addr_t       mem_addr, wpf_addr, npf_addr;
   logic [31:0] rd;
   int          k, n0, num_errors = 0, checks = 0;
   always #50 clk_sys = ~clk_sys;
   // short timeout keeps the stalled-bus case quick
   peripheral_frame_decoder #(.WAIT_MAX(8'h04)) uut (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .cpu_req(cpu_req), .cpu_we(cpu_we),
      .cpu_size32(cpu_size32), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
      .prot_unlock(prot_unlock), .prot_lock(prot_lock),
      .csu_permit(csu_permit), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
      .mem_req(mem_req), .mem_we(mem_we), .mem_size32(mem_size32),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .wpf_req(wpf_req), .wpf_we(wpf_we), .wpf_size32(wpf_size32),
      .wpf_addr(wpf_addr),
      .wpf_wdata(wpf_wdata), .wpf_prot_ok(wpf_prot_ok),
      .wpf_rdata(wpf_rdata), .wpf_ready(wpf_ready), .npf_req(npf_req),
      .npf_we(npf_we), .npf_addr(npf_addr), .npf_wdata(npf_wdata),
      .npf_rdata(npf_rdata), .npf_ready(npf_ready));
   frame_side_model fs (.clk_sys(clk_sys), .lat(lat), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .wpf_req(wpf_req), .wpf_we(wpf_we),
      .wpf_addr(wpf_addr), .wpf_wdata(wpf_wdata),
      .wpf_prot_ok(wpf_prot_ok), .wpf_rdata(wpf_rdata),
      .wpf_ready(wpf_ready), .npf_req(npf_req), .npf_we(npf_we),
      .npf_addr(npf_addr), .npf_wdata(npf_wdata), .npf_rdata(npf_rdata),
      .npf_ready(npf_ready));
   // one access; k counts edges from the take to the ack, take included
   task automatic acc(input logic w, input logic s, input addr_t a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      #1;
      cpu_req    = 1'b1;
      cpu_we     = w;
      cpu_size32 = s;
      cpu_addr   = a;
      cpu_wdata  = d;
      @(posedge clk_sys);
      #1;
      cpu_req = 1'b0;
      k = 1;
      while (cpu_ack !== 1'b1 && k < 40) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      if (cpu_ack !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t no ack from decoder", $time);
      end
      rd = cpu_rdata;
   endtask
   task automatic prot(input logic u, input logic l);
      @(posedge clk_sys);
      #1;
      prot_unlock = u;
      prot_lock   = l;
      @(posedge clk_sys);
      #1;
      prot_unlock = 1'b0;
      prot_lock   = 1'b0;
   endtask
   task automatic t_mem;
      n0 = fs.mem_n;
      acc(1'b1, 1'b0, 22'h00_0880, 32'h0000_1111);
      `CHK(k, 1)
      `CHK(fs.mem_n, n0)
      prot(1'b1, 1'b0);
      acc(1'b1, 1'b1, 22'h00_0880, 32'h1234_5678);
      `CHK(k, 2)
      `CHK(fs.last_data, 32'h1234_5678)
      `CHK(fs.last_we, 1'b1)
      `CHK(mem_size32, 1'b1)
      `CHK(rd, 32'h0000_0000)
      acc(1'b0, 1'b0, 22'h00_0C05, 32'h0000_0000);
      `CHK(rd[15:0], 16'h0C05)
      `CHK(mem_size32, 1'b0)
      acc(1'b0, 1'b1, 22'h00_0C06, 32'h0000_0000);
      `CHK(rd, 32'h565C_0C06)
      prot(1'b0, 1'b1);
      acc(1'b1, 1'b0, 22'h00_0D10, 32'h0000_2222);
      `CHK(k, 1)
      acc(1'b1, 1'b0, 22'h00_0CE0, 32'h0000_3333);
      `CHK(k, 2)
      prot(1'b1, 1'b1);
      acc(1'b1, 1'b0, 22'h00_0D10, 32'h0000_2222);
      `CHK(k, 1)
      $display("t_mem done");
   endtask
   task automatic t_flash;
      prot(1'b1, 1'b0);
      csu_permit = 1'b0;
      acc(1'b1, 1'b0, 22'h00_0A80, 32'h0000_00A5);
      `CHK(k, 1)
      csu_permit = 1'b1;
      acc(1'b1, 1'b0, 22'h00_0ADF, 32'h0000_005A);
      `CHK(k, 2)
      `CHK(fs.last_addr, 22'h00_0ADF)
      prot(1'b0, 1'b1);
      acc(1'b1, 1'b0, 22'h00_0AEF, 32'h0000_0001);
      `CHK(k, 1)
      acc(1'b0, 1'b0, 22'h00_0AE0, 32'h0000_0000);
      `CHK(k, 2)
      n0 = fs.mem_n;
      acc(1'b0, 1'b1, 22'h00_0AF0, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      acc(1'b1, 1'b0, 22'h00_0A00, 32'h0000_7777);
      `CHK(fs.mem_n, n0)
      $display("t_flash done");
   endtask
   task automatic t_wide;
      lat = 5'h03;
      acc(1'b0, 1'b1, 22'h00_6101, 32'h0000_0000);
      `CHK(rd, 32'h6101_6100)
      `CHK(fs.last_addr, 22'h00_6100)
      `CHK(wpf_size32, 1'b1)
      `CHK(k, 5)
      n0 = fs.wpf_n;
      acc(1'b1, 1'b0, 22'h00_6000, 32'h0000_3333);
      `CHK(k, 1)
      `CHK(fs.wpf_n, n0)
      acc(1'b1, 1'b1, 22'h00_6010, 32'hCAFE_0001);
      `CHK(fs.last_ok, 1'b0)
      `CHK(fs.last_data, 32'hCAFE_0001)
      prot(1'b1, 1'b0);
      acc(1'b1, 1'b1, 22'h00_6010, 32'hCAFE_0002);
      `CHK(fs.last_ok, 1'b1)
      prot(1'b0, 1'b1);
      acc(1'b1, 1'b0, 22'h00_6180, 32'h0000_4444);
      `CHK(fs.last_ok, 1'b1)
      lat = 5'h0F;
      acc(1'b0, 1'b1, 22'h00_6100, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      `CHK(k <= 7, 1'b1)
      $display("t_wide done");
   endtask
   task automatic t_narrow;
      lat = 5'h00;
      acc(1'b0, 1'b0, 22'h00_7040, 32'h0000_0000);
      `CHK(rd, 32'h0000_B383)
      `CHK(k, 2)
      acc(1'b1, 1'b0, 22'h00_7050, 32'h0000_BEEF);
      `CHK(fs.last_data, 32'h0000_BEEF)
      `CHK(fs.last_we, 1'b1)
      acc(1'b0, 1'b0, 22'h00_7800, 32'h0000_0000);
      `CHK(rd, 32'h0000_BBC3)
      n0 = fs.npf_n;
      acc(1'b1, 1'b1, 22'h00_7040, 32'h5555_6666);
      `CHK(k, 1)
      `CHK(fs.npf_n, n0)
      acc(1'b1, 1'b0, 22'h00_7010, 32'h0000_0101);
      `CHK(k, 1)
      acc(1'b0, 1'b0, 22'h00_7000, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      `CHK(fs.npf_n, n0)
      $display("t_narrow done");
   endtask
   // reset in mid-run must drop an earlier unlock
   task automatic t_reset;
      prot(1'b1, 1'b0);
      @(posedge clk_sys);
      #1;
      sys_rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      n0 = fs.mem_n;
      acc(1'b1, 1'b0, 22'h00_0880, 32'h0000_1234);
      `CHK(k, 1)
      `CHK(fs.mem_n, n0)
      $display("t_reset done");
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      t_mem();
      t_flash();
      t_wide();
      t_narrow();
      t_reset();
      summarize();
   end
   // whole run needs well under a thousand cycles
   initial begin
      #2_000_000;
      num_errors++;
      summarize();
   end
endmodule // peripheral_frame_decoder_tb_top
`default_nettype wire
